/* File: verilog/slsp_params.svh */
// Constants for the shared lock semaphore pool
`ifndef SLSP_PARAMS_SVH
`define SLSP_PARAMS_SVH
`define SLSP_NUM_LOCKS   8
`define SLSP_ID_W        3
`define SLSP_NUM_CORES   4
`define SLSP_RES_W       8
`define SLSP_NONE_RESULT 8'hff
`define SLSP_STATES_RST  8'h00
`define SLSP_USED_RST    8'h00
`endif

/* File: verilog/slsp_pkg.sv */
// Types for the shared lock semaphore pool
`include "slsp_params.svh"
package slsp_pkg;
  typedef enum logic [1:0] {
    SLSP_CMD_CHECKOUT,
    SLSP_CMD_RETURN,
    SLSP_CMD_SET,
    SLSP_CMD_CLEAR
  } slsp_cmd_t;
  typedef logic [`SLSP_ID_W-1:0] slsp_id_t;
endpackage

/* File: verilog/slsp_if.sv */
// Interface joining the cores' end and the lock pool
`timescale 1ns/1ps
`include "slsp_params.svh"
interface slsp_if (input wire logic CLOCK, input wire logic RST);
  import slsp_pkg::*;
  logic [`SLSP_NUM_CORES-1:0] req;
  slsp_cmd_t                  cmd   [`SLSP_NUM_CORES];
  slsp_id_t                   id    [`SLSP_NUM_CORES];
  logic [`SLSP_NUM_CORES-1:0] done;
  logic [`SLSP_RES_W-1:0]     result;
  modport pool (input CLOCK, input RST, input req, input cmd, input id,
                output done, output result);
  modport cores (input CLOCK, input RST, output req, output cmd, output id,
                 input done, input result);
endinterface

/* File: verilog/slsp_pool.sv */
// Central lock pool with round-robin serialising arbiter
`timescale 1ns/1ps
`include "slsp_params.svh"
module slsp_pool
  import slsp_pkg::*;
(
  slsp_if.pool                  bus,        // Link to the cores' end
  output logic [`SLSP_NUM_LOCKS-1:0] STATES, // Lock bits
  output logic [`SLSP_NUM_LOCKS-1:0] USED    // Checked-out flags
);
  // Sizes fixed by the pool
  localparam int NC = `SLSP_NUM_CORES;
  localparam int NL = `SLSP_NUM_LOCKS;
  localparam int RW = `SLSP_RES_W;
  localparam int IW = `SLSP_ID_W;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // One-hot mask of a lock
  function automatic logic [NL-1:0] lock_hot(input slsp_id_t n);
    logic [NL-1:0] m;
    m    = '0;
    m[n] = 1'b1;
    return m;
  endfunction

  // One-hot mask of a core
  function automatic logic [NC-1:0] core_hot(input logic [1:0] n);
    logic [NC-1:0] m;
    m    = '0;
    m[n] = 1'b1;
    return m;
  endfunction

  // Core index counted on from a base
  function automatic logic [1:0] core_at(input logic [1:0] base,
                                         input logic [1:0] step);
    return 2'(base + step);
  endfunction

  // Lock bit widened to the answer
  function automatic logic [RW-1:0] bit_answer(input logic b);
    return {{(RW-1){1'b0}}, b};
  endfunction

  // Identifier widened to the answer
  function automatic logic [RW-1:0] id_answer(input slsp_id_t n);
    return {{(RW-IW){1'b0}}, n};
  endfunction

  // ----------------------------------------
  // Registers and next values
  // ----------------------------------------
  logic [NL-1:0] states_ff;   // Lock bits
  logic [NL-1:0] nxt_states;
  logic [NL-1:0] used_ff;     // Checked-out flags
  logic [NL-1:0] nxt_used;
  logic [NC-1:0] done_ff;     // Served-core pulse
  logic [NC-1:0] nxt_done;
  logic [RW-1:0] result_ff;   // Answer of the last command
  logic [RW-1:0] nxt_result;
  logic [1:0]    ptr_ff;      // Rotation start
  logic [1:0]    nxt_ptr;

  // ----------------------------------------
  // Decode wires
  // ----------------------------------------
  logic [1:0]    gnt;
  logic          gnt_vld;
  logic          pend;
  slsp_cmd_t     g_cmd;
  slsp_id_t      g_id;
  slsp_id_t      free_id;
  logic          any_free;
  logic [NL-1:0] id_mask;
  logic [NL-1:0] free_mask;

  // Command decode
  logic          do_take;
  logic          do_give;
  logic          do_set;
  logic          do_clear;
  logic          old_bit;
  logic [RW-1:0] take_answer;
  logic [RW-1:0] flag_answer;

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  // First requesting core in rotation from the pointer wins; the core just served is masked
  always_comb begin
    gnt     = 2'h0;
    gnt_vld = 1'b0;
    for (int k = NC-1; k >= 0; k--) begin
      if (bus.req[core_at(ptr_ff, 2'(k))] && !done_ff[core_at(ptr_ff, 2'(k))]) begin
        gnt     = core_at(ptr_ff, 2'(k));
        gnt_vld = 1'b1;
      end
    end
  end

  // A command is taken only while no answer stands
  assign pend     = gnt_vld && (done_ff == '0);
  assign g_cmd    = bus.cmd[gnt];
  assign g_id     = bus.id[gnt];
  assign nxt_done = pend ? core_hot(gnt) : '0;
  assign nxt_ptr  = pend ? core_at(gnt, 2'h1) : ptr_ff;

  // ----------------------------------------
  // Lock selection
  // ----------------------------------------
  // Lowest free lock
  always_comb begin
    free_id  = 3'h0;
    any_free = 1'b0;
    for (int k = NL-1; k >= 0; k--) begin
      if (!used_ff[k]) begin
        free_id  = 3'(k);
        any_free = 1'b1;
      end
    end
  end

  // One command acts per taken cycle
  assign do_take   = pend && (g_cmd == SLSP_CMD_CHECKOUT) && any_free;
  assign do_give   = pend && (g_cmd == SLSP_CMD_RETURN);
  assign do_set    = pend && (g_cmd == SLSP_CMD_SET);
  assign do_clear  = pend && (g_cmd == SLSP_CMD_CLEAR);
  assign id_mask   = lock_hot(g_id);
  assign free_mask = lock_hot(free_id);
  assign old_bit   = states_ff[g_id];

  // ----------------------------------------
  // Per-lock next state
  // ----------------------------------------
  generate
    for (genvar l = 0; l < NL; l++) begin : g_lock
      // Lock bit and flag follow the one command taken
      assign nxt_states[l] = (do_set && id_mask[l])   ? 1'b1 :
                             (do_clear && id_mask[l]) ? 1'b0 :
                                                        states_ff[l];
      assign nxt_used[l]   = (do_take && free_mask[l]) ? 1'b1 :
                             (do_give && id_mask[l])   ? 1'b0 :
                                                         used_ff[l];
    end
  endgenerate

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  // All ones when no lock is free
  assign take_answer = any_free ? id_answer(free_id) : `SLSP_NONE_RESULT;
  assign flag_answer = bit_answer(old_bit);

  // Return answers zero
  always_comb begin
    case (g_cmd)
      SLSP_CMD_CHECKOUT: nxt_result = take_answer;
      SLSP_CMD_RETURN:   nxt_result = '0;
      SLSP_CMD_SET:      nxt_result = flag_answer;
      SLSP_CMD_CLEAR:    nxt_result = flag_answer;
      default:           nxt_result = '0;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Lock bits and checked-out flags
  always_ff @(posedge bus.CLOCK or posedge bus.RST) begin
    if (bus.RST) begin
      states_ff <= `SLSP_STATES_RST;
      used_ff   <= `SLSP_USED_RST;
    end else begin
      states_ff <= nxt_states;
      used_ff   <= nxt_used;
    end
  end

  // Served pulse and rotation pointer
  always_ff @(posedge bus.CLOCK or posedge bus.RST) begin
    if (bus.RST) begin
      done_ff <= '0;
      ptr_ff  <= 2'h0;
    end else begin
      done_ff <= nxt_done;
      ptr_ff  <= nxt_ptr;
    end
  end

  // Answer holds until the next command is taken
  always_ff @(posedge bus.CLOCK or posedge bus.RST) begin
    if (bus.RST) begin
      result_ff <= '0;
    end else if (pend) begin
      result_ff <= nxt_result;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.done   = done_ff;
  assign bus.result = result_ff;
  assign STATES     = states_ff;
  assign USED       = used_ff;
endmodule // slsp_pool

/* File: verilog/slsp_cores.sv */
// Cores' end: per-core command ports onto the lock pool link
`timescale 1ns/1ps
`include "slsp_params.svh"
module slsp_cores
  import slsp_pkg::*;
(
  slsp_if.cores                    bus,       // Link to the lock pool
  input  wire logic [`SLSP_NUM_CORES-1:0] REQ, // Per-core request start, pulse
  input  wire slsp_cmd_t           CMD [`SLSP_NUM_CORES], // Command per core
  input  wire slsp_id_t            ID  [`SLSP_NUM_CORES], // Lock id per core
  output logic [`SLSP_NUM_CORES-1:0] BUSY,    // Request pending
  output logic [`SLSP_NUM_CORES-1:0] DONE,    // Answer ready, pulse
  output logic [`SLSP_RES_W-1:0]   RESULT [`SLSP_NUM_CORES] // Answer
);
  // ----------------------------------------
  // Request holding per core
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < `SLSP_NUM_CORES; c++) begin : g_core
      logic            busy_ff;
      logic            done_ff;
      slsp_cmd_t       cmd_ff;
      slsp_id_t        id_ff;
      logic [`SLSP_RES_W-1:0] res_ff;
      always_ff @(posedge bus.CLOCK or posedge bus.RST) begin
        if (bus.RST) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b0;
          cmd_ff  <= SLSP_CMD_CHECKOUT;
          id_ff   <= '0;
          res_ff  <= '0;
        end else begin
          done_ff <= 1'b0;
          if (busy_ff && bus.done[c]) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            res_ff  <= bus.result;
          end else if (!busy_ff && REQ[c]) begin
            busy_ff <= 1'b1;
            cmd_ff  <= CMD[c];
            id_ff   <= ID[c];
          end
        end
      end
      assign bus.req[c] = busy_ff;
      assign bus.cmd[c] = cmd_ff;
      assign bus.id[c]  = id_ff;
      assign BUSY[c]    = busy_ff;
      assign DONE[c]    = done_ff;
      assign RESULT[c]  = res_ff;
    end
  endgenerate
endmodule // slsp_cores

/* File: dv/slsp_sva.sv */
// Checker on the lock pool link
`timescale 1ns/1ps
`include "slsp_params.svh"
module slsp_sva
  import slsp_pkg::*;
(
  input wire logic                        CLOCK,  // Clock
  input wire logic                        RST,    // Reset
  input wire logic [`SLSP_NUM_CORES-1:0]  req,    // Requests
  input wire slsp_cmd_t                   cmd [`SLSP_NUM_CORES], // Commands
  input wire slsp_id_t                    id  [`SLSP_NUM_CORES], // Lock ids
  input wire logic [`SLSP_NUM_CORES-1:0]  done,   // Served
  input wire logic [`SLSP_RES_W-1:0]      result, // Answer
  input wire logic [`SLSP_NUM_LOCKS-1:0]  STATES, // Lock bits
  input wire logic [`SLSP_NUM_LOCKS-1:0]  USED    // Checked out
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_one_grant: assert property ($onehot0(done)) else $error("two served");
  chk_grant_req: assert property ((done & ~req) == '0) else $error("done no req");
  chk_grant_gap: assert property (|done |=> done == '0) else $error("back to back");
  chk_reset_free: assert property ($fell(RST) |-> STATES == 8'h00 && USED == 8'h00)
    else $error("not free after reset");
  for (genvar c = 0; c < `SLSP_NUM_CORES; c++) begin : g_core
    chk_set_old: assert property (done[c] && cmd[c] == SLSP_CMD_SET |->
      STATES[id[c]] && result == {7'h00, $past(STATES[id[c]])}) else $error("set");
    chk_clear_old: assert property (done[c] && cmd[c] == SLSP_CMD_CLEAR |->
      !STATES[id[c]] && result == {7'h00, $past(STATES[id[c]])}) else $error("clear");
    chk_take_free: assert property (done[c] && cmd[c] == SLSP_CMD_CHECKOUT &&
      result != 8'hff |-> result[7:3] == 5'h00 && USED[result[2:0]] &&
      ($past(USED) & (8'h01 << result[2:0])) == 8'h00) else $error("checkout");
    chk_take_none: assert property (done[c] && cmd[c] == SLSP_CMD_CHECKOUT &&
      result == 8'hff |-> $past(USED) == 8'hff && $stable(USED)) else $error("full");
    chk_ret_free: assert property (done[c] && cmd[c] == SLSP_CMD_RETURN |->
      !USED[id[c]] && result == 8'h00) else $error("return");
  end
endmodule // slsp_sva

/* File: dv/tb_top.sv */
// Testbench for both ends of the lock pool link
`timescale 1ns/1ps
`include "slsp_params.svh"
module tb_top;
  import slsp_pkg::*;
  logic       CLOCK = 1'b0;
  logic       RST   = 1'b1;
  logic [3:0] req   = 4'h0;
  slsp_cmd_t  cmd [4];
  slsp_id_t   id  [4];
  logic [3:0] busy, done;
  logic [7:0] res [4];
  logic [7:0] st_w, used_w, st, e;
  logic [7:0] q [$];
  int         errors = 0, tests_run = 0, cyc = 0, seed = 32'hc8a0, i;
  always #5 CLOCK = ~CLOCK;
  slsp_if bus (.CLOCK(CLOCK), .RST(RST));
  slsp_pool u_slsp_pool (.bus(bus), .STATES(st_w), .USED(used_w));
  slsp_cores u_slsp_cores (.bus(bus), .REQ(req), .CMD(cmd), .ID(id), .BUSY(busy),
    .DONE(done), .RESULT(res));
  slsp_sva u_slsp_sva (.CLOCK(CLOCK), .RST(RST), .req(bus.req), .cmd(bus.cmd), .id(bus.id),
    .done(bus.done), .result(bus.result), .STATES(st_w), .USED(used_w));
  task check(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task op(int c, slsp_cmd_t m, slsp_id_t n, logic [7:0] exp);
    q.push_back(exp);
    @(posedge CLOCK);
    req[c] <= 1'b1;
    cmd[c] <= m;
    id[c] <= n;
    @(posedge CLOCK);
    req[c] <= 1'b0;
    @(negedge CLOCK);
    while (busy[c] !== 1'b0) @(negedge CLOCK);
  endtask
  // Oldest note against each answer
  always @(negedge CLOCK) begin
    for (int k = 0; k < 4; k++)
      if (done[k] === 1'b1) check(res[k], q.size() ? q.pop_front() : 8'h55);
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    foreach (cmd[j]) begin
      cmd[j] = SLSP_CMD_CHECKOUT;
      id[j] = 3'h0;
    end
    st = 8'h00;
    repeat (12) @(posedge CLOCK);
    RST <= 1'b0;
    for (i = 0; i < 9; i++) op($random(seed) & 3, SLSP_CMD_CHECKOUT, 3'h0,
      (i < 8) ? 8'(i) : 8'hff);
    $display("test checkout done");
    op(2, SLSP_CMD_RETURN, 3'h5, 8'h00);
    op(1, SLSP_CMD_CHECKOUT, 3'h0, 8'h05);
    op(0, SLSP_CMD_RETURN, 3'h6, 8'h00);
    check(used_w, 8'hbf);
    $display("test return done");
    for (i = 0; i < 24; i++) begin
      e = $random(seed);
      op(e[5:4], e[0] ? SLSP_CMD_SET : SLSP_CMD_CLEAR, e[3:1], {7'h00, st[e[3:1]]});
      st[e[3:1]] = e[0];
    end
    check(st_w, st);
    $display("test set clear done");
    op(3, SLSP_CMD_CLEAR, 3'h7, {7'h00, st[7]});
    q = {q, 8'h00, 8'h01, 8'h01, 8'h01};
    @(posedge CLOCK);
    req <= 4'hf;
    foreach (cmd[j]) begin
      cmd[j] <= SLSP_CMD_SET;
      id[j] <= 3'h7;
    end
    @(posedge CLOCK);
    req <= 4'h0;
    repeat (20) @(posedge CLOCK);
    op(1, SLSP_CMD_SET, 3'h7, 8'h01);
    op(2, SLSP_CMD_CLEAR, 3'h7, 8'h01);
    op(1, SLSP_CMD_SET, 3'h7, 8'h00);
    st[7] = 1'b1;
    @(posedge CLOCK);
    check(st_w, st);
    check(8'(q.size()), 8'h00);
    $display("test contention done");
    close_out;
  end
endmodule // tb_top
